// File: src/secl_ctrl_end.sv
// Controller end: Avalon-MM command registers and two-wire byte engine
`timescale 1ns/1ps
`default_nettype none
module secl_ctrl_end #(
    parameter int QTR_CYCLES = secl_pkg::SCL_QTR_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RESET,
    input  wire logic [1:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output var logic  [31:0] AVS_READDATA,
    output var logic         AVS_WAITREQUEST,
    secl_link_if.ctrl        LINK
);
    import secl_pkg::*;

    localparam int QW = $clog2(QTR_CYCLES);

    if (QTR_CYCLES < 2) begin : g_chk
        $error("QTR_CYCLES must be at least two");
    end

    secl_mstate_type st_q;
    logic [QW-1:0]   qcnt_q;
    logic [1:0]      ph_q;
    logic [3:0]      bit_q;
    logic            stop_f_q;
    logic            read_f_q;
    logic            mack_q;
    logic [7:0]      tx_q;
    logic [7:0]      rx_q;
    logic            busy_q;
    logic            nack_q;
    logic            hold_q;
    logic            scl_q;
    logic            low_q;
    logic            meta_q;
    logic            sda_s;
    logic            wait_q;
    logic [31:0]     rdata_q;
    logic [31:0]     cmd_q;
    logic [31:0]     status;
    logic            tick;
    logic            launch;
    logic            bit_val;
    logic            scl_d;
    logic            low_d;

    assign tick   = qcnt_q == QW'(QTR_CYCLES - 1);
    assign launch = AVS_WRITE && !wait_q && (AVS_ADDRESS == REG_CMD) && !busy_q;

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            meta_q <= 1'b1;
            sda_s  <= 1'b1;
        end else begin
            meta_q <= LINK.sda;
            sda_s  <= meta_q;
        end
    end

    // Byte engine: optional Start, nine bit slots, optional Stop
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_q     <= M_IDLE;
            qcnt_q   <= '0;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            stop_f_q <= 1'b0;
            read_f_q <= 1'b0;
            mack_q   <= 1'b0;
            tx_q     <= 8'h00;
            rx_q     <= 8'h00;
            busy_q   <= 1'b0;
            nack_q   <= 1'b0;
            hold_q   <= 1'b1;
        end else if (launch) begin
            st_q     <= AVS_WRITEDATA[CMD_START_POS] ? M_START : M_BITS;
            qcnt_q   <= '0;
            ph_q     <= 2'h0;
            bit_q    <= 4'h0;
            stop_f_q <= AVS_WRITEDATA[CMD_STOP_POS];
            read_f_q <= AVS_WRITEDATA[CMD_READ_POS];
            mack_q   <= AVS_WRITEDATA[CMD_MACK_POS];
            tx_q     <= AVS_WRITEDATA[CMD_TX_LSB +: 8];
            busy_q   <= 1'b1;
        end else if (st_q != M_IDLE) begin
            qcnt_q <= tick ? '0 : qcnt_q + 1'b1;
            if (tick) begin
                ph_q <= ph_q + 1'b1;
                if (st_q == M_BITS && ph_q == 2'h2) begin
                    if (bit_q != ACK_SLOT) begin
                        rx_q <= {rx_q[6:0], sda_s};
                    end else if (!read_f_q) begin
                        nack_q <= sda_s;
                    end
                end
                if (ph_q == 2'h3) begin
                    case (st_q)
                        M_START: begin
                            st_q  <= M_BITS;
                            bit_q <= 4'h0;
                        end
                        M_BITS: begin
                            if (bit_q != ACK_SLOT) begin
                                bit_q <= bit_q + 1'b1;
                            end else if (stop_f_q) begin
                                st_q <= M_STOP;
                            end else begin
                                st_q   <= M_IDLE;
                                busy_q <= 1'b0;
                                hold_q <= 1'b0;
                            end
                        end
                        M_STOP: begin
                            st_q   <= M_IDLE;
                            busy_q <= 1'b0;
                            hold_q <= 1'b1;
                        end
                        default: st_q <= M_IDLE;
                    endcase
                end
            end
        end
    end

    // Line levels per state and quarter phase
    always_comb begin
        if (bit_q != ACK_SLOT) begin
            bit_val = read_f_q | tx_q[3'(LAST_BIT - bit_q)];
        end else begin
            bit_val = !(read_f_q && mack_q);
        end
        scl_d = hold_q;
        low_d = 1'b0;
        case (st_q)
            M_START: begin
                scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
                low_d = ph_q[1];
            end
            M_BITS: begin
                scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
                low_d = !bit_val;
            end
            M_STOP: begin
                scl_d = ph_q != 2'h0;
                low_d = !ph_q[1];
            end
            default: begin
                scl_d = hold_q;
                low_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            scl_q <= 1'b1;
            low_q <= 1'b0;
        end else begin
            scl_q <= scl_d;
            low_q <= low_d;
        end
    end

    always_comb begin
        status                           = 32'h0000_0000;
        status[STAT_BUSY_POS]            = busy_q;
        status[STAT_NACK_POS]            = nack_q;
        status[STAT_RX_LSB +: 8]         = rx_q;
    end

    // Avalon slave: every access answers on the second edge
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
            cmd_q   <= CMD_RESET;
        end else begin
            wait_q <= !((AVS_READ || AVS_WRITE) && wait_q);
            if (AVS_READ && wait_q) begin
                case (AVS_ADDRESS)
                    REG_CMD:    rdata_q <= cmd_q;
                    REG_STATUS: rdata_q <= status;
                    default:    rdata_q <= 32'h0000_0000;
                endcase
            end
            if (launch) begin
                cmd_q <= AVS_WRITEDATA;
            end
        end
    end

    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign LINK.scl        = scl_q;
    assign LINK.sda_m_out  = 1'b0;
    assign LINK.sda_m_oe   = low_q;
endmodule : secl_ctrl_end
`default_nettype wire

// File: src/secl_link_if.sv
// Two-wire link between the controller end and the EEPROM end
`timescale 1ns/1ps
`default_nettype none
interface secl_link_if;
    logic      scl;
    logic      sda_m_out;
    logic      sda_m_oe;
    logic      sda_s_out;
    logic      sda_s_oe;
    wire logic sda;

    // Open-drain wired AND with pull-up
    assign sda = (sda_m_oe ? sda_m_out : 1'b1) & (sda_s_oe ? sda_s_out : 1'b1);

    modport ctrl (output scl, output sda_m_out, output sda_m_oe, input sda);
    modport mem  (input scl, output sda_s_out, output sda_s_oe, input sda);
endinterface : secl_link_if
`default_nettype wire

// File: src/secl_mem_end.sv
// EEPROM end: control byte match, addressing, page buffer, reads
//
// The register offsets and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module secl_mem_end #(
    parameter int WRITE_LEN = secl_pkg::WRITE_CYCLES
) (
    input  wire logic       REF_CLK,
    input  wire logic       RESET,
    secl_link_if.mem        LINK,
    input  wire logic [2:0] CHIP_SEL,
    input  wire logic       WRITE_PROTECT,
    output var logic        WRITE_BUSY
);
    import secl_pkg::*;

    localparam int CNT_W = $clog2(WRITE_LEN + 1);

    if (WRITE_LEN < 1) begin : g_chk
        $error("WRITE_LEN must be at least one");
    end

    logic [5:0]              meta_q;
    logic [5:0]              sync_q;
    logic [5:0]              prev_q;
    logic [5:0]              pins;
    logic                    scl_s;
    logic                    sda_s;
    logic                    scl_p;
    logic                    sda_p;
    logic [2:0]              cs_s;
    logic                    wp_s;
    logic                    start_ev;
    logic                    stop_ev;
    logic                    rise;
    logic                    fall;
    secl_sstate_type         state_q;
    logic [3:0]              cnt_q;
    logic [7:0]              sh_q;
    logic [7:0]              tx_q;
    logic                    rw_q;
    logic                    drive_q;
    logic [ADDR_W-1:0]       ptr_q;
    logic [6:0]              addr_hi_q;
    logic                    cs_ok;
    logic                    wr_byte;
    logic                    launch;
    logic                    commit;
    logic                    clr_buf;
    logic                    busy_q;
    logic [CNT_W-1:0]        wcnt_q;
    logic [ADDR_W-PAGE_W-1:0] page_q;
    logic [PAGE_BYTES-1:0]   pval_q;
    logic [7:0]              pbuf_q [PAGE_BYTES];
    logic [7:0]              mem_q  [MEM_BYTES];

    // Pins pass two flip-flops; prev_q keeps the last synchronised sample
    assign pins = {WRITE_PROTECT, CHIP_SEL, LINK.sda, LINK.scl};

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            meta_q <= 6'h03;
            sync_q <= 6'h03;
            prev_q <= 6'h03;
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign scl_s    = sync_q[0];
    assign sda_s    = sync_q[1];
    assign cs_s     = sync_q[4:2];
    assign wp_s     = sync_q[5];
    assign scl_p    = prev_q[0];
    assign sda_p    = prev_q[1];
    assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
    assign stop_ev  = scl_s & scl_p & ~sda_p & sda_s;
    assign rise     = scl_s & ~scl_p;
    assign fall     = ~scl_s & scl_p;

    assign cs_ok   = (sh_q[7:4] == CTRL_CODE) && (sh_q[3:1] == cs_s) && !busy_q;
    assign wr_byte = fall && (state_q == S_WDATA) && (cnt_q == LAST_BIT);
    assign launch  = stop_ev && (|pval_q) && !busy_q && !wp_s;
    assign commit  = busy_q && (wcnt_q == CNT_W'(1));
    assign clr_buf = (start_ev || stop_ev) && !busy_q && !launch;

    // Byte-level protocol engine
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            state_q   <= S_IDLE;
            cnt_q     <= 4'h0;
            sh_q      <= 8'h00;
            tx_q      <= 8'hFF;
            rw_q      <= 1'b0;
            drive_q   <= 1'b0;
            ptr_q     <= '0;
            addr_hi_q <= 7'h00;
        end else if (start_ev) begin
            state_q <= S_CTRL;
            cnt_q   <= 4'hF; // The Start's own clock fall wraps this to zero
            drive_q <= 1'b0;
        end else if (stop_ev) begin
            state_q <= S_IDLE;
            drive_q <= 1'b0;
        end else begin
            if (rise && cnt_q != ACK_SLOT && state_q != S_RDATA && state_q != S_IDLE) begin
                sh_q <= {sh_q[6:0], sda_s};
            end
            if (rise && cnt_q == ACK_SLOT && state_q == S_RDATA && sda_s) begin
                state_q <= S_IDLE;
            end
            if (fall && state_q != S_IDLE) begin
                if (cnt_q == LAST_BIT) begin
                    cnt_q <= ACK_SLOT;
                    if (state_q == S_RDATA) begin
                        drive_q <= 1'b0;
                        ptr_q   <= ptr_q + 1'b1;
                    end else if (state_q == S_CTRL && !cs_ok) begin
                        state_q <= S_IDLE;
                        drive_q <= 1'b0;
                    end else begin
                        drive_q <= 1'b1;
                        case (state_q)
                            S_CTRL:  rw_q <= sh_q[0];
                            S_ADDRH: addr_hi_q <= sh_q[6:0];
                            S_ADDRL: ptr_q <= {addr_hi_q, sh_q};
                            S_WDATA: ptr_q[PAGE_W-1:0] <= ptr_q[PAGE_W-1:0] + 1'b1;
                            default: rw_q <= rw_q;
                        endcase
                    end
                end else if (cnt_q == ACK_SLOT) begin
                    cnt_q   <= 4'h0;
                    drive_q <= 1'b0;
                    case (state_q)
                        S_CTRL: begin
                            if (rw_q) begin
                                state_q <= S_RDATA;
                                tx_q    <= mem_q[ptr_q];
                                drive_q <= ~mem_q[ptr_q][7];
                            end else begin
                                state_q <= S_ADDRH;
                            end
                        end
                        S_ADDRH: state_q <= S_ADDRL;
                        S_ADDRL: state_q <= S_WDATA;
                        S_RDATA: begin
                            tx_q    <= mem_q[ptr_q];
                            drive_q <= ~mem_q[ptr_q][7];
                        end
                        default: state_q <= state_q;
                    endcase
                end else begin
                    cnt_q <= cnt_q + 1'b1;
                    if (state_q == S_RDATA) begin
                        tx_q    <= {tx_q[6:0], 1'b1};
                        drive_q <= ~tx_q[6];
                    end
                end
            end
        end
    end

    // Page buffer fill; kept for the write cycle once launched
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            pval_q <= '0;
        end else if (commit || clr_buf) begin
            pval_q <= '0;
        end else if (wr_byte) begin
            pval_q[ptr_q[PAGE_W-1:0]] <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (wr_byte) begin
            pbuf_q[ptr_q[PAGE_W-1:0]] <= sh_q;
        end
    end

    // Self-timed write cycle
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            busy_q <= 1'b0;
            wcnt_q <= '0;
            page_q <= '0;
        end else if (launch) begin
            busy_q <= 1'b1;
            wcnt_q <= CNT_W'(WRITE_LEN);
            page_q <= ptr_q[ADDR_W-1:PAGE_W];
        end else if (busy_q) begin
            wcnt_q <= wcnt_q - 1'b1;
            if (commit) begin
                busy_q <= 1'b0;
            end
        end
    end

    // Array update at the end of the write cycle
    always_ff @(posedge REF_CLK) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (pval_q[i]) begin
                    mem_q[{page_q, PAGE_W'(i)}] <= pbuf_q[i];
                end
            end
        end
    end

    assign LINK.sda_s_out = 1'b0;
    assign LINK.sda_s_oe  = drive_q;
    assign WRITE_BUSY     = busy_q;
endmodule : secl_mem_end
`default_nettype wire

// File: src/secl_pkg.sv
// Shared constants and types for the serial EEPROM command logic
package secl_pkg;
    localparam logic [3:0]  CTRL_CODE      = 4'hA;
    localparam int          ADDR_W         = 15;
    localparam int          PAGE_W         = 6;
    localparam int          MEM_BYTES      = 1 << ADDR_W;
    localparam int          PAGE_BYTES     = 1 << PAGE_W;
    localparam logic [3:0]  LAST_BIT       = 4'h7;
    localparam logic [3:0]  ACK_SLOT       = 4'h8;
    localparam int          T_CLK_NS       = 5;
    localparam int          T_WRITE_NS     = 5000000;
    localparam int          WRITE_CYCLES   = T_WRITE_NS / T_CLK_NS;
    localparam int          T_SCL_NS       = 2500;
    localparam int          SCL_QTR_CYCLES = T_SCL_NS / (4 * T_CLK_NS);
    localparam logic [1:0]  REG_CMD        = 2'h0;
    localparam logic [1:0]  REG_STATUS     = 2'h1;
    localparam int          CMD_START_POS  = 0;
    localparam int          CMD_STOP_POS   = 1;
    localparam int          CMD_READ_POS   = 2;
    localparam int          CMD_MACK_POS   = 3;
    localparam int          CMD_TX_LSB     = 8;
    localparam int          STAT_BUSY_POS  = 0;
    localparam int          STAT_NACK_POS  = 1;
    localparam int          STAT_RX_LSB    = 8;
    localparam logic [31:0] CMD_RESET      = 32'h0000_0000;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_CTRL  = 3'h1,
        S_ADDRH = 3'h2,
        S_ADDRL = 3'h3,
        S_WDATA = 3'h4,
        S_RDATA = 3'h5
    } secl_sstate_type;

    typedef enum logic [1:0] {
        M_IDLE  = 2'h0,
        M_START = 2'h1,
        M_BITS  = 2'h2,
        M_STOP  = 2'h3
    } secl_mstate_type;
endpackage : secl_pkg

// File: tb/secl_bench.sv
// Self-checking bench joining the controller end and the EEPROM end
`timescale 1ns/1ps
`default_nettype none
module secl_bench;
    import secl_pkg::*;
    localparam int QTR   = 8;
    localparam int WLEN  = 600;
    localparam int LIMIT = 95000;
    logic        clk;
    logic        rst;
    logic [1:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [2:0]  chip_sel;
    logic        write_protect;
    logic        write_busy;
    logic [31:0] seed;
    logic [31:0] w;
    logic [14:0] base;
    logic        nack;
    logic [7:0]  rxb;
    logic [7:0]  ref_mem [int];
    int          failures;
    int          checks_done;
    int          cycles;

    secl_link_if link ();
    secl_ctrl_end #(.QTR_CYCLES(QTR)) u_secl_ctrl_end (.REF_CLK(clk), .RESET(rst),
        .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
        .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .LINK(link));
    secl_mem_end #(.WRITE_LEN(WLEN)) u_secl_mem_end (.REF_CLK(clk), .RESET(rst), .LINK(link),
        .CHIP_SEL(chip_sel), .WRITE_PROTECT(write_protect), .WRITE_BUSY(write_busy));
    secl_props #(.WRITE_LEN(WLEN)) u_secl_props (.REF_CLK(clk), .RESET(rst), .scl(link.scl),
        .sda_m_out(link.sda_m_out), .sda_m_oe(link.sda_m_oe), .sda_s_out(link.sda_s_out),
        .sda_s_oe(link.sda_s_oe), .sda(link.sda), .WRITE_BUSY(write_busy),
        .WRITE_PROTECT(write_protect));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [14:0] wrap_addr(input logic [14:0] a, input int i);
        return {a[14:6], a[5:0] + i[5:0]};
    endfunction : wrap_addr

    task automatic print_verdict;
        $display("Comparisons %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            $display("Error timeout expected end seen none");
            print_verdict();
        end
    end

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk_val

    task automatic av_xfer(input logic wr, input logic [1:0] adr, input logic [31:0] wd,
                           output logic [31:0] rd);
        avs_address   <= adr;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= wd;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask : av_xfer

    task automatic byte_op(input logic st, input logic sp, input logic rdb, input logic mack,
                           input logic [7:0] tx, output logic nk, output logic [7:0] rx);
        logic [31:0] s;
        int          n;
        av_xfer(1'b1, REG_CMD, {16'h0000, tx, 4'h0, mack, rdb, sp, st}, s);
        n = 0;
        do begin
            av_xfer(1'b0, REG_STATUS, 32'h0000_0000, s);
            n++;
        end while (s[STAT_BUSY_POS] !== 1'b0 && n < 200);
        chk_val("byte engine idle", 32'h0, s[STAT_BUSY_POS]);
        nk = s[STAT_NACK_POS];
        rx = s[STAT_RX_LSB +: 8];
    endtask : byte_op

    task automatic ctrl(input logic rdb, input logic sp, output logic nk);
        logic [7:0] rx;
        byte_op(1'b1, sp, 1'b0, 1'b0, {CTRL_CODE, chip_sel, rdb}, nk, rx);
    endtask : ctrl

    task automatic set_addr(input logic [14:0] a);
        logic       nk;
        logic [7:0] rx;
        logic [31:0] r;
        r = $random(seed);
        ctrl(1'b0, 1'b0, nk);
        chk_val("control ack", 32'h0, nk);
        byte_op(1'b0, 1'b0, 1'b0, 1'b0, {r[0], a[14:8]}, nk, rx);
        chk_val("address high ack", 32'h0, nk);
        byte_op(1'b0, 1'b0, 1'b0, 1'b0, a[7:0], nk, rx);
        chk_val("address low ack", 32'h0, nk);
    endtask : set_addr

    task automatic write_bytes(input logic [14:0] a, input int n);
        logic       nk;
        logic [7:0] rx;
        logic [7:0] b;
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            b = $random(seed);
            byte_op(1'b0, i == n - 1, 1'b0, 1'b0, b, nk, rx);
            chk_val("data ack", 32'h0, nk);
            if (!write_protect) begin
                ref_mem[wrap_addr(a, i)] = b;
            end
        end
    endtask : write_bytes

    task automatic read_seq(input logic [14:0] a, input logic cur, input int n);
        logic       nk;
        logic [7:0] rx;
        logic [14:0] ea;
        if (!cur) begin
            set_addr(a);
        end
        ctrl(1'b1, 1'b0, nk);
        chk_val("read control ack", 32'h0, nk);
        for (int i = 0; i < n; i++) begin
            byte_op(1'b0, i == n - 1, 1'b1, i < n - 1, 8'h00, nk, rx);
            ea = a + 15'(i);
            chk_val("read byte", ref_mem[ea], rx);
        end
    endtask : read_seq

    task automatic poll(input logic busy_exp);
        logic nk;
        int   n;
        n = 0;
        do begin
            ctrl(1'b0, 1'b1, nk);
            if (n == 0) begin
                chk_val("first poll nack", busy_exp, nk);
            end
            n++;
        end while (nk !== 1'b0 && n < 20);
        chk_val("poll final ack", 32'h0, nk);
    endtask : poll

    initial begin
        seed = 32'h04C1;
        rst = 1'b1;
        avs_address = 2'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        chip_sel = 3'h0;
        write_protect = 1'b0;
        failures = 0;
        checks_done = 0;
        cycles = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        chip_sel <= $random(seed);
        repeat (8) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            byte_op(1'b1, 1'b1, 1'b0, 1'b0, i < 3 ? {CTRL_CODE, chip_sel ^ 3'(1 << i), 1'b0}
                    : {4'hB, chip_sel, 1'b0}, nack, rxb);
            chk_val("foreign control nack", 32'h1, nack);
        end
        av_xfer(1'b0, REG_CMD, 32'h0, w);
        chk_val("command readback", {16'h0000, 4'hB, chip_sel, 1'b0, 8'h03}, w);
        av_xfer(1'b1, 2'h3, $random(seed), w);
        av_xfer(1'b0, 2'h3, 32'h0, w);
        chk_val("unmapped read", 32'h0, w);
        $display("test refusals done");
        w = $random(seed);
        base = {w[14:6], 6'h00};
        write_bytes(base, 3);
        poll(1'b1);
        write_bytes(base, 1);
        poll(1'b1);
        read_seq(base + 15'h1, 1'b1, 1);
        $display("test byte write done");
        write_bytes(base + 15'h3C, 66);
        poll(1'b1);
        read_seq(base, 1'b0, 64);
        read_seq(base + 15'h5, 1'b0, 1);
        read_seq(base + 15'h6, 1'b1, 1);
        $display("test page write done");
        write_protect <= 1'b1;
        repeat (4) @(posedge clk);
        write_bytes(base + 15'h2, 1);
        poll(1'b0);
        write_protect <= 1'b0;
        read_seq(base + 15'h2, 1'b0, 1);
        write_bytes(base + 15'h7, 1);
        write_protect <= 1'b1;
        poll(1'b1);
        write_protect <= 1'b0;
        read_seq(base + 15'h7, 1'b0, 1);
        $display("test protect done");
        write_bytes(15'h7FFF, 1);
        poll(1'b1);
        write_bytes(15'h0000, 1);
        poll(1'b1);
        read_seq(15'h7FFF, 1'b0, 2);
        $display("test wrap done");
        chip_sel <= chip_sel & 3'h4;
        repeat (4) @(posedge clk);
        read_seq(15'h7FFF, 1'b0, 1);
        $display("test select zero done");
        print_verdict();
    end
endmodule : secl_bench
`default_nettype wire

// File: tb/secl_props.sv
// Concurrent checks on the two-wire link between the two ends and on the write cycle
`timescale 1ns/1ps
`default_nettype none
module secl_props #(
    parameter int WRITE_LEN = secl_pkg::WRITE_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic scl,
    input wire logic sda_m_out,
    input wire logic sda_m_oe,
    input wire logic sda_s_out,
    input wire logic sda_s_oe,
    input wire logic sda,
    input wire logic WRITE_BUSY,
    input wire logic WRITE_PROTECT
);
    logic       scl_p_q;
    logic       sda_p_q;
    logic       wp_stop_q;
    logic [3:0] stop_age_q;
    int         busy_cnt_q;
    logic       stop_ev;
    logic       start_ev;

    assign stop_ev  = scl && scl_p_q && sda && !sda_p_q;
    assign start_ev = scl && scl_p_q && !sda && sda_p_q;

    always_ff @(posedge REF_CLK) begin
        scl_p_q <= scl;
        sda_p_q <= sda;
    end

    // Protect level seen on the wire at each Stop
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            wp_stop_q <= 1'b0;
        end else if (stop_ev) begin
            wp_stop_q <= WRITE_PROTECT;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            stop_age_q <= 4'hF;
        end else if (stop_ev) begin
            stop_age_q <= 4'h0;
        end else if (stop_age_q != 4'hF) begin
            stop_age_q <= stop_age_q + 4'h1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET || !WRITE_BUSY) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 1;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    a_busy_length: assert property ($fell(WRITE_BUSY) |-> busy_cnt_q == WRITE_LEN)
        else $error("write cycle length differs from its setting");
    a_busy_bound: assert property (WRITE_BUSY |-> busy_cnt_q < WRITE_LEN)
        else $error("write cycle overruns its setting");
    a_quiet_busy: assert property (WRITE_BUSY |-> !sda_s_oe)
        else $error("device drives data line during write cycle");
    a_protect_blocks: assert property ($rose(WRITE_BUSY) |-> !wp_stop_q)
        else $error("write cycle started with protect high at Stop");
    a_busy_after_stop: assert property ($rose(WRITE_BUSY) |-> stop_age_q <= 4'hC)
        else $error("write cycle not started right after a Stop");
    a_slave_steady: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
        else $error("device changes data line while clock high");
    a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high phase too short");
    a_start_free: assert property (start_ev |-> !sda_s_oe)
        else $error("device holds data line at a Start");
endmodule : secl_props
`default_nettype wire
